// ==== hdl/ccbc_defs.svh ====
// constants of the clock and bridge boot configuration register
`ifndef CCBC_DEFS_SVH
`define CCBC_DEFS_SVH
`define CCBC_OFFSET_CFG 12'h02c
`define CCBC_WRITE_MASK 32'h1fff_fe00
`define CCBC_CFG_RESET 32'h0010_c400
`define CCBC_WIDTH_RESET 2'h2
`define CCBC_BIT_SLV_INCR 28
`define CCBC_BIT_M2_INCR 27
`define CCBC_BIT_M1_INCR 26
`define CCBC_BIT_PASST 25
`define CCBC_BIT_SLV_ASYNC 24
`define CCBC_BIT_M2_ASYNC 23
`define CCBC_BIT_M1_ASYNC 22
`define CCBC_FLD_SMC_HI 21
`define CCBC_FLD_SMC_LO 20
`define CCBC_FLD_GFX_HI 19
`define CCBC_FLD_GFX_LO 18
`define CCBC_FLD_FB_HI 17
`define CCBC_FLD_FB_LO 15
`define CCBC_FLD_BUS_HI 14
`define CCBC_FLD_BUS_LO 13
`define CCBC_BIT_SHORTFB 12
`define CCBC_BIT_BYPASS 11
`define CCBC_BIT_USEPLL 10
`define CCBC_BIT_CSPOL 9
`define CCBC_FLD_WIDTH_HI 8
`define CCBC_FLD_WIDTH_LO 7
`define CCBC_RATIO_SMC_RESET 4'h2
`define CCBC_RATIO_GFX_RESET 4'h1
`define CCBC_RATIO_FB_RESET 4'h2
`define CCBC_RATIO_BUS_RESET 4'h3
`endif

// ==== hdl/ccbc_pkg.sv ====
// types of the clock and bridge boot configuration register
package ccbc_pkg;
	typedef logic [31:0] ccbc_word_t;
	typedef logic [11:0] ccbc_addr_t;
	typedef logic [3:0] ccbc_ratio_t;
	// boot memory data width encoding
	typedef enum logic [1:0] {
		CCBC_W8 = 2'h0,
		CCBC_W16 = 2'h1,
		CCBC_W32 = 2'h2,
		CCBC_WRSV = 2'h3
	} ccbc_width_e;
endpackage

// ==== hdl/ccbc_config_reg.sv ====
// apb slave holding the clock, bridge and boot configuration register
//
// Chosen here: the register addresses and the APB register port.
`include "ccbc_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module ccbc_config_reg #(
	parameter logic [1:0] BOOT_WIDTH_CS0 = 2'h2,
	parameter logic [1:0] BOOT_WIDTH_CS1 = 2'h2,
	parameter logic [1:0] BOOT_WIDTH_CS2 = 2'h2,
	parameter logic [1:0] BOOT_WIDTH_CS3 = 2'h2
) (
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire ccbc_pkg::ccbc_addr_t PADDR,
	input wire ccbc_pkg::ccbc_word_t PWDATA,
	input wire logic [3:0] PSTRB,
	output ccbc_pkg::ccbc_word_t PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic FORCE_ASYNC_SW,
	input wire logic [1:0] BOOT_CS_SELECTOR,
	output logic SLAVE_BRIDGE_BURST_OVERRIDE,
	output logic MASTER2_BRIDGE_BURST_OVERRIDE,
	output logic MASTER1_BRIDGE_BURST_OVERRIDE,
	output logic BRIDGE_PASSTHROUGH_EN,
	output logic SLAVE_BRIDGE_ASYNC,
	output logic MASTER2_BRIDGE_ASYNC,
	output logic MASTER1_BRIDGE_ASYNC,
	output ccbc_pkg::ccbc_ratio_t STATIC_MEM_CLK_RATIO,
	output ccbc_pkg::ccbc_ratio_t GRAPHICS_CLK_RATIO,
	output ccbc_pkg::ccbc_ratio_t FEEDBACK_CLK_RATIO,
	output ccbc_pkg::ccbc_ratio_t BUS_CLK_RATIO,
	output logic PLL_SHORT_FEEDBACK,
	output logic PLL_BYPASS,
	output logic PLL_CLOCK_SELECT,
	output logic BOOT_CS_POLARITY,
	output ccbc_pkg::ccbc_width_e BOOT_MEM_WIDTH
);
	import ccbc_pkg::*;

	// a divide field value n means divide by n plus one
	function automatic ccbc_ratio_t div_ratio(input logic [2:0] sel);
		div_ratio = {1'b0, sel} + 4'h1;
	endfunction

	// boot width of the memory behind a selector value
	function automatic ccbc_width_e width_of(input logic [1:0] sel);
		unique case (sel)
			2'h0: width_of = ccbc_width_e'(BOOT_WIDTH_CS0);
			2'h1: width_of = ccbc_width_e'(BOOT_WIDTH_CS1);
			2'h2: width_of = ccbc_width_e'(BOOT_WIDTH_CS2);
			2'h3: width_of = ccbc_width_e'(BOOT_WIDTH_CS3);
		endcase
	endfunction

	ccbc_word_t cfg_reg;
	ccbc_word_t cfg_next;
	ccbc_word_t prdata_reg;
	ccbc_word_t prdata_next;
	ccbc_word_t strb_mask;
	ccbc_word_t wr_mask;
	ccbc_word_t read_word;
	ccbc_width_e width_reg;
	ccbc_width_e width_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic hit;
	logic setup;
	logic wr_commit;
	logic [6:0] bridge_reg;
	logic [6:0] bridge_next;
	ccbc_ratio_t smc_ratio_reg;
	ccbc_ratio_t gfx_ratio_reg;
	ccbc_ratio_t fb_ratio_reg;
	ccbc_ratio_t bus_ratio_reg;
	logic [3:0] pll_reg;
	logic [3:0] pll_next;

	// address decode: one register, every other offset answers with an error
	assign hit = (PADDR == `CCBC_OFFSET_CFG);
	assign setup = PSEL && !PENABLE;
	assign wr_commit = PSEL && PENABLE && PREADY && PWRITE && hit;

	// byte strobes narrow the write; read-only and reserved lanes never open
	assign strb_mask = {{8{PSTRB[3]}}, {8{PSTRB[2]}}, {8{PSTRB[1]}}, {8{PSTRB[0]}}};
	assign wr_mask = strb_mask & `CCBC_WRITE_MASK;
	assign cfg_next = wr_commit ? ((cfg_reg & ~wr_mask) | (PWDATA & wr_mask)) : cfg_reg;

	// read word: bits 31:29 and 6:0 zero, width field from the registered boot width
	assign read_word = (cfg_reg & `CCBC_WRITE_MASK)
		| ({30'h0000_0000, width_reg} << `CCBC_FLD_WIDTH_LO);

	// answer is prepared in the setup cycle so that every bus output is a flop
	assign pready_next = setup;
	assign pslverr_next = setup && !hit;
	assign prdata_next = (setup && !PWRITE && hit) ? read_word : 32'h0000_0000;

	// boot width follows the two selector switches through the width table
	assign width_next = width_of(BOOT_CS_SELECTOR);

	// bridge controls; the board switch overrides all three async bits
	assign bridge_next = {
		cfg_reg[`CCBC_BIT_SLV_INCR],
		cfg_reg[`CCBC_BIT_M2_INCR],
		cfg_reg[`CCBC_BIT_M1_INCR],
		cfg_reg[`CCBC_BIT_PASST],
		cfg_reg[`CCBC_BIT_SLV_ASYNC] | FORCE_ASYNC_SW,
		cfg_reg[`CCBC_BIT_M2_ASYNC] | FORCE_ASYNC_SW,
		cfg_reg[`CCBC_BIT_M1_ASYNC] | FORCE_ASYNC_SW
	};

	// pll controls
	assign pll_next = {
		cfg_reg[`CCBC_BIT_SHORTFB],
		cfg_reg[`CCBC_BIT_BYPASS],
		cfg_reg[`CCBC_BIT_USEPLL],
		cfg_reg[`CCBC_BIT_CSPOL]
	};

	// the register itself, defaults loaded at reset
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			cfg_reg <= `CCBC_CFG_RESET;
			width_reg <= ccbc_width_e'(`CCBC_WIDTH_RESET);
		end else begin
			cfg_reg <= cfg_next;
			width_reg <= width_next;
		end
	end

	// bus answer flops
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
		end
	end

	// control output flops; they lag the register by one edge, a trade for clean outputs
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			bridge_reg <= 7'h00;
			pll_reg <= 4'h2;
			smc_ratio_reg <= `CCBC_RATIO_SMC_RESET;
			gfx_ratio_reg <= `CCBC_RATIO_GFX_RESET;
			fb_ratio_reg <= `CCBC_RATIO_FB_RESET;
			bus_ratio_reg <= `CCBC_RATIO_BUS_RESET;
		end else begin
			bridge_reg <= bridge_next;
			pll_reg <= pll_next;
			smc_ratio_reg <= div_ratio({1'b0, cfg_reg[`CCBC_FLD_SMC_HI:`CCBC_FLD_SMC_LO]});
			gfx_ratio_reg <= div_ratio({1'b0, cfg_reg[`CCBC_FLD_GFX_HI:`CCBC_FLD_GFX_LO]});
			fb_ratio_reg <= div_ratio(cfg_reg[`CCBC_FLD_FB_HI:`CCBC_FLD_FB_LO]);
			bus_ratio_reg <= div_ratio({1'b0, cfg_reg[`CCBC_FLD_BUS_HI:`CCBC_FLD_BUS_LO]});
		end
	end

	// output wiring, all straight from flops
	assign PREADY = pready_reg;
	assign PSLVERR = pslverr_reg;
	assign PRDATA = prdata_reg;
	assign SLAVE_BRIDGE_BURST_OVERRIDE = bridge_reg[6];
	assign MASTER2_BRIDGE_BURST_OVERRIDE = bridge_reg[5];
	assign MASTER1_BRIDGE_BURST_OVERRIDE = bridge_reg[4];
	assign BRIDGE_PASSTHROUGH_EN = bridge_reg[3];
	assign SLAVE_BRIDGE_ASYNC = bridge_reg[2];
	assign MASTER2_BRIDGE_ASYNC = bridge_reg[1];
	assign MASTER1_BRIDGE_ASYNC = bridge_reg[0];
	assign PLL_SHORT_FEEDBACK = pll_reg[3];
	assign PLL_BYPASS = pll_reg[2];
	assign PLL_CLOCK_SELECT = pll_reg[1];
	assign BOOT_CS_POLARITY = pll_reg[0];
	assign STATIC_MEM_CLK_RATIO = smc_ratio_reg;
	assign GRAPHICS_CLK_RATIO = gfx_ratio_reg;
	assign FEEDBACK_CLK_RATIO = fb_ratio_reg;
	assign BUS_CLK_RATIO = bus_ratio_reg;
	assign BOOT_MEM_WIDTH = width_reg;

	// checks, all in the one clock domain
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!NRST);

	// reserved and left-out bits never read as one
	AST_RSV_ZERO: assert property (PREADY |-> (PRDATA[31:29] == 3'h0 && PRDATA[6:0] == 7'h00))
		else $error("reserved read bits not zero");

	// a write to bit 28 shows on the slave override two edges later
	AST_SLV_INCR: assert property (wr_commit && PSTRB[3] |-> ##2
		SLAVE_BRIDGE_BURST_OVERRIDE == $past(PWDATA[28], 2))
		else $error("slave burst override does not follow write");

	// master burst overrides and pass-through follow the register
	AST_M_INCR: assert property (##1 {MASTER2_BRIDGE_BURST_OVERRIDE, MASTER1_BRIDGE_BURST_OVERRIDE,
		BRIDGE_PASSTHROUGH_EN} == $past(cfg_reg[27:25]))
		else $error("bridge burst or pass-through output wrong");

	// switch forces all three async outputs high one edge later
	AST_FORCE: assert property (FORCE_ASYNC_SW |=> (SLAVE_BRIDGE_ASYNC && MASTER2_BRIDGE_ASYNC
		&& MASTER1_BRIDGE_ASYNC))
		else $error("force switch not honoured");

	// switch off: each async output is its own bit
	AST_OWN_BIT: assert property (!FORCE_ASYNC_SW |=> ({SLAVE_BRIDGE_ASYNC, MASTER2_BRIDGE_ASYNC,
		MASTER1_BRIDGE_ASYNC} == $past(cfg_reg[24:22])))
		else $error("async output differs from register bit");

	// ratios are field plus one
	AST_RATIO: assert property (##1 (STATIC_MEM_CLK_RATIO == {2'h0, $past(cfg_reg[21:20])} + 4'h1
		&& FEEDBACK_CLK_RATIO == {1'b0, $past(cfg_reg[17:15])} + 4'h1))
		else $error("divide ratio wrong");

	AST_RATIO2: assert property (##1 (GRAPHICS_CLK_RATIO == {2'h0, $past(cfg_reg[19:18])} + 4'h1
		&& BUS_CLK_RATIO == {2'h0, $past(cfg_reg[14:13])} + 4'h1))
		else $error("divide ratio wrong");

	// defaults hold right after reset release
	AST_DEFAULTS: assert property ($rose(NRST) |-> (BUS_CLK_RATIO == 4'h3
		&& FEEDBACK_CLK_RATIO == 4'h2 && PLL_CLOCK_SELECT && !PLL_BYPASS))
		else $error("reset defaults wrong");

	// pll controls follow their bits
	AST_PLL: assert property (##1 {PLL_SHORT_FEEDBACK, PLL_BYPASS, PLL_CLOCK_SELECT,
		BOOT_CS_POLARITY} == $past(cfg_reg[12:9]))
		else $error("pll or polarity output wrong");

	// width tracks the selector a cycle later
	AST_WIDTH: assert property (##1 BOOT_MEM_WIDTH == width_of($past(BOOT_CS_SELECTOR)))
		else $error("boot width does not follow selector");

	// writes never touch read-only or reserved bits
	AST_RO: assert property (wr_commit |=> (cfg_reg[31:29] == 3'h0 && cfg_reg[8:0] == 9'h000
		&& cfg_reg[8:7] == 2'h0))
		else $error("read-only bit written");

	// every access is answered in the cycle after setup
	AST_ANSWER: assert property (setup |=> PREADY ##1 !PREADY)
		else $error("bus answer timing wrong");

	// an error answer only ever comes with ready
	AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
		else $error("error flag without ready");

	// an error answer never carries data
	AST_ERR_DATA_ZERO: assert property (PSLVERR |-> PRDATA == 32'h0000_0000)
		else $error("error answer carries data");

	// read data stands only in the answer cycle
	AST_RDATA_IDLE: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
		else $error("read data outside the answer cycle");

	// ready is a one-cycle pulse
	AST_READY_PULSE: assert property (PREADY |=> !PREADY)
		else $error("ready held longer than one cycle");

	// read answer reports the width that stood at setup
	AST_READ_WIDTH: assert property (PREADY && !PSLVERR && !$past(PWRITE)
		|-> PRDATA[8:7] == $past(BOOT_MEM_WIDTH))
		else $error("read width field wrong");

	// read answer returns the held writable bits
	AST_READ_FIELDS: assert property (PREADY && !PSLVERR && !$past(PWRITE)
		|-> PRDATA[28:9] == $past(cfg_reg[28:9]))
		else $error("read fields differ from register");

	// without a committed write the register holds still
	AST_HOLD: assert property (!wr_commit |=> $stable(cfg_reg))
		else $error("register changed without a write");

	// a write to an unmapped offset leaves the register alone
	AST_UNMAPPED_WR: assert property (PSEL && PENABLE && PWRITE && !hit |=> $stable(cfg_reg))
		else $error("unmapped write changed the register");

	// a closed top lane keeps bits 28:24
	AST_LANE3_KEEP: assert property (wr_commit && !PSTRB[3]
		|=> cfg_reg[28:24] == $past(cfg_reg[28:24]))
		else $error("closed lane 3 written");

	// a closed lane 2 keeps bits 23:16
	AST_LANE2_KEEP: assert property (wr_commit && !PSTRB[2]
		|=> cfg_reg[23:16] == $past(cfg_reg[23:16]))
		else $error("closed lane 2 written");

	// lane 0 alone holds no writable bit
	AST_LANE0_ONLY: assert property (wr_commit && PSTRB == 4'h1 |=> $stable(cfg_reg))
		else $error("lane 0 write changed the register");

	// pass-through follows a written bit 25 two edges later
	AST_PASST_WR: assert property (wr_commit && PSTRB[3] |-> ##2
		BRIDGE_PASSTHROUGH_EN == $past(PWDATA[25], 2))
		else $error("pass-through does not follow write");

	// master overrides follow written bits 27 and 26
	AST_M_INCR_WR: assert property (wr_commit && PSTRB[3] |-> ##2
		{MASTER2_BRIDGE_BURST_OVERRIDE, MASTER1_BRIDGE_BURST_OVERRIDE}
		== $past(PWDATA[27:26], 2))
		else $error("master burst override does not follow write");

	// with the switch off, master 1 async follows a written bit 22
	AST_M1_ASYNC_WR: assert property (wr_commit && PSTRB[2] ##1 !FORCE_ASYNC_SW
		|=> MASTER1_BRIDGE_ASYNC == $past(PWDATA[22], 2))
		else $error("master 1 async does not follow write");

	// pll bypass follows a written bit 11
	AST_BYPASS_WR: assert property (wr_commit && PSTRB[1] |-> ##2
		PLL_BYPASS == $past(PWDATA[11], 2))
		else $error("pll bypass does not follow write");

	// ratios stay inside what their fields can give
	AST_RATIO_RANGE: assert property (STATIC_MEM_CLK_RATIO >= 4'h1 && STATIC_MEM_CLK_RATIO <= 4'h4
		&& GRAPHICS_CLK_RATIO >= 4'h1 && GRAPHICS_CLK_RATIO <= 4'h4
		&& FEEDBACK_CLK_RATIO >= 4'h1 && FEEDBACK_CLK_RATIO <= 4'h8
		&& BUS_CLK_RATIO >= 4'h1 && BUS_CLK_RATIO <= 4'h4)
		else $error("divide ratio out of range");

	// the other defaults after release: memory and graphics ratios, controls low
	AST_DEFAULTS2: assert property ($rose(NRST) |-> (STATIC_MEM_CLK_RATIO == 4'h2
		&& GRAPHICS_CLK_RATIO == 4'h1 && !SLAVE_BRIDGE_BURST_OVERRIDE
		&& !BRIDGE_PASSTHROUGH_EN && !PLL_SHORT_FEEDBACK && !BOOT_CS_POLARITY))
		else $error("reset defaults wrong");

	// main scenarios seen
	COV_WRITE: cover property (wr_commit);
	COV_PART_WRITE: cover property (wr_commit && PSTRB != 4'hf);
	COV_READ: cover property (PSEL && PENABLE && PREADY && !PWRITE && hit);
	COV_FORCE: cover property (FORCE_ASYNC_SW ##1 !FORCE_ASYNC_SW);
	COV_ERR: cover property (PSLVERR);
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for the clock, bridge and boot configuration register
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import ccbc_pkg::*;
	// boot width per selector value, deliberately not the identity so a swap shows
	localparam logic [1:0] WTAB [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	ccbc_addr_t paddr = 12'h000;
	ccbc_word_t pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'h0;
	logic sw = 1'b0;
	logic [1:0] sel = 2'h2;
	ccbc_word_t prdata;
	logic pready, pslverr, so, m2o, m1o, pt, sa, m2a, m1a, sfb, byp, usp, csp;
	ccbc_ratio_t r_smc, r_gfx, r_fb, r_bus;
	ccbc_width_e bw;
	ccbc_word_t mreg = 32'h0010_c400;
	ccbc_word_t rd;
	logic er;
	int err_count = 0;
	int n_compared = 0;
	// all control outputs packed in one word so a single compare covers them
	wire logic [31:0] outs = {3'h0, so, m2o, m1o, pt, sa, m2a, m1a,
		r_smc, r_gfx, r_fb, r_bus, sfb, byp, usp, csp, bw};

	always #5 clk = ~clk;

	ccbc_config_reg #(.BOOT_WIDTH_CS0(WTAB[0]), .BOOT_WIDTH_CS1(WTAB[1]),
		.BOOT_WIDTH_CS2(WTAB[2]), .BOOT_WIDTH_CS3(WTAB[3])) dut (
		.CLK_SYS(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .FORCE_ASYNC_SW(sw), .BOOT_CS_SELECTOR(sel),
		.SLAVE_BRIDGE_BURST_OVERRIDE(so), .MASTER2_BRIDGE_BURST_OVERRIDE(m2o),
		.MASTER1_BRIDGE_BURST_OVERRIDE(m1o), .BRIDGE_PASSTHROUGH_EN(pt),
		.SLAVE_BRIDGE_ASYNC(sa), .MASTER2_BRIDGE_ASYNC(m2a), .MASTER1_BRIDGE_ASYNC(m1a),
		.STATIC_MEM_CLK_RATIO(r_smc), .GRAPHICS_CLK_RATIO(r_gfx),
		.FEEDBACK_CLK_RATIO(r_fb), .BUS_CLK_RATIO(r_bus), .PLL_SHORT_FEEDBACK(sfb),
		.PLL_BYPASS(byp), .PLL_CLOCK_SELECT(usp), .BOOT_CS_POLARITY(csp),
		.BOOT_MEM_WIDTH(bw));

	// expected control outputs: divisors are field plus one, the switch ors into async
	function automatic logic [31:0] exp_outs(input logic [31:0] r, input logic s,
		input logic [1:0] b);
		return {3'h0, r[28:25], r[24] | s, r[23] | s, r[22] | s, {2'h0, r[21:20]} + 4'h1,
			{2'h0, r[19:18]} + 4'h1, {1'h0, r[17:15]} + 4'h1, {2'h0, r[14:13]} + 4'h1,
			r[12:9], b};
	endfunction

	// readback: only bits 28:9 hold written data, 8:7 report the boot width
	function automatic logic [31:0] exp_rd(input logic [1:0] b);
		return (mreg & 32'h1fff_fe00) | {23'h0, b, 7'h00};
	endfunction

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// one apb transfer; pready is taken at the rising edge, as it stood before the edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		if (pready !== 1'b1) begin
			err_count++;
			$display("unexpected pready: expected 1, seen %b", pready);
			give_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, 12'h02c, d, s);
		for (int b = 0; b < 4; b++) if (s[b]) mreg[8*b +: 8] = d[8*b +: 8];
		chk("write error flag", 32'h0, {31'h0, er});
	endtask

	task automatic rd_chk(input logic [1:0] b);
		apb(1'b0, 12'h02c, 32'h0, 4'h0);
		chk("config word", exp_rd(b), rd);
	endtask

	// outputs lag the register by one edge, so let two edges pass first
	task automatic outs_chk(input logic [1:0] b);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("control outputs", exp_outs(mreg, sw, b), outs);
	endtask

	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		outs_chk(2'h2);
		rd_chk(2'h2);
		$display("test reset defaults done");
		wr(32'hffff_ffff, 4'hf);
		rd_chk(2'h2);
		outs_chk(2'h2);
		wr(32'h0000_0000, 4'hf);
		rd_chk(2'h2);
		outs_chk(2'h2);
		$display("test full write done");
		for (int k = 22; k < 25; k++) begin
			wr(32'h1 << k, 4'hf);
			outs_chk(2'h2);
			@(posedge clk);
			sw <= 1'b1;
			outs_chk(2'h2);
			@(posedge clk);
			sw <= 1'b0;
		end
		$display("test async force done");
		for (int b = 0; b < 4; b++) begin
			wr(32'hffff_ffff, 4'h1 << b);
			rd_chk(2'h2);
		end
		$display("test byte lanes done");
		apb(1'b1, 12'h030, 32'h0000_0000, 4'hf);
		chk("unmapped write error", 32'h1, {31'h0, er});
		rd_chk(2'h2);
		apb(1'b0, 12'h028, 32'h0000_0000, 4'h0);
		chk("unmapped read error", 32'h1, {31'h0, er});
		chk("unmapped read data", 32'h0, rd);
		$display("test unmapped address done");
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			sel <= s[1:0];
			outs_chk(WTAB[s]);
			rd_chk(WTAB[s]);
		end
		$display("test boot selector done");
		give_verdict();
	end
endmodule
`default_nettype wire
